/* pkg/pwm_timer_defs.vh */
/*
 header of register offsets, field positions and reset values for the
 two-channel three-phase pwm timer; included by the timer module and its bench.
*/
`ifndef PWM_TIMER_DEFS_VH
`define PWM_TIMER_DEFS_VH

// printed offsets; word index is offset less the base, byte address four times it
`define IDX_BASE 16'hc000
`define OFS_START 16'hf030
`define OFS_SYNC 16'hf031
`define OFS_CH1_CTRL 16'hf040
`define OFS_CH1_MODE 16'hf041
`define OFS_CH1_PIN 16'hf042
`define OFS_CH1_CNT 16'hf046
`define OFS_CH1_GRA 16'hf048
`define OFS_CH1_GRB 16'hf04a
`define OFS_CH2_CTRL 16'hf050
`define OFS_CH2_MODE 16'hf051
`define OFS_CH2_PIN 16'hf052
`define OFS_CH2_CNT 16'hf056
`define OFS_CH2_GRA 16'hf058
`define OFS_CH2_GRB 16'hf05a

// field positions
`define RUN_CH1_BIT 1
`define RUN_CH2_BIT 2
`define CLR_SRC_HI 6
`define CLR_SRC_LO 5
`define EDGE_HI 4
`define EDGE_LO 3
`define PRESCALE_HI 2
`define PRESCALE_LO 0

// encodings
`define MODE_PWM2 2'h3
`define CLR_BY_GRB 2'h2
`define CLR_BY_SYNC 2'h3
`define EDGE_RISING 2'h0
`define PRESCALE_DIV4 3'h1
`define PIN_OFF 4'h0
`define PIN_LOW_THEN_HIGH 4'h2

// reset values
`define CNT_RESET 16'h0000
`define GR_RESET 16'hffff
`define CTRL_RESET 8'h00
`define PIN_RESET 8'h00
`define MODE_RESET 8'hc0

// system clock divided by four
`define DIV4_LAST 2'h3

`endif

/* src/three_phase_pwm_timer_pair.v */
/*
 two synchronised 16-bit timer channels in pwm mode 2 with an avalon-mm slave.
 assumes a single clk, synchronous active-high sys_rst, and a master that holds
 each request until waitrequest is seen low; registers sit at word indexes
 of their printed offset less a fixed block base.
*/
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "pwm_timer_defs.vh"

// How it works
// - channel 1 mode field bits 1..0 equal 11 selects pwm mode 2.
// - channel 2 mode field bits 1..0 equal 11 selects pwm mode 2.
// - pin setup register: bits 7..4 for compare b, 3..0 for compare a.
// - field 0010: output compare, pin starts low, goes high on match.
// - field 0000: compare still works, pin output disabled.
// - each counter is 16-bit read/write up-counter, zero at reset.
// - counters and compare registers only take whole 16-bit accesses.
// - every compare register resets to all ones.
// - compare registers are 16-bit read/write compare values.
// - channel 2 clear field 10 clears its counter on compare b match.
// - edge field 00 counts on rising edge of selected count clock.
// - prescale field 001 counts on system clock divided by four.
// - channel 1 clear field 11 clears when other synced channel clears.
// - sync bit joins channel to simultaneous presetting and clearing.
// - counter counts only while its start bit is one.
module three_phase_pwm_timer_pair (
	input wire clk,
	input wire sys_rst,
	input wire [15:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	output reg pwm_out_phase1,
	output reg pwm_out_phase2,
	output reg pwm_out_phase3,
	output reg ch2_pin_b_unused
);

	reg [7:0] start_reg;
	reg [7:0] sync_reg;
	reg [7:0] ch1_counter_control;
	reg [7:0] ch1_operating_mode;
	reg [7:0] ch1_pin_compare_setup;
	reg [15:0] ch1_up_counter;
	reg [15:0] ch1_compare_a_duty;
	reg [15:0] ch1_compare_b_duty;
	reg [7:0] ch2_counter_control;
	reg [7:0] ch2_operating_mode;
	reg [7:0] ch2_pin_compare_setup;
	reg [15:0] ch2_up_counter;
	reg [15:0] ch2_compare_a_duty;
	reg [15:0] ch2_compare_b_period;
	reg [1:0] prescale_cnt;
	reg answered;
	reg [31:0] next_readdata;
	reg [15:0] next_ch1_up_counter;
	reg [15:0] next_ch2_up_counter;

	wire ch1_run_bit = start_reg[`RUN_CH1_BIT];
	wire ch2_run_bit = start_reg[`RUN_CH2_BIT];
	wire ch1_sync_join = sync_reg[`RUN_CH1_BIT];
	wire ch2_sync_join = sync_reg[`RUN_CH2_BIT];

	// count clock enable: divided clock with rising edge selected
	function tick_sel;
		input [7:0] ctrl;
		input div4_edge;
		begin
			tick_sel = (ctrl[`PRESCALE_HI:`PRESCALE_LO] == `PRESCALE_DIV4) &&
				(ctrl[`EDGE_HI:`EDGE_LO] == `EDGE_RISING) && div4_edge;
		end
	endfunction

	// pin drive for one 4-bit field, given current level and events
	function pin_next;
		input [3:0] cfg;
		input cur;
		input match;
		input restart;
		begin
			if (cfg == `PIN_LOW_THEN_HIGH) begin
				if (restart)
					pin_next = 1'b0;
				else if (match)
					pin_next = 1'b1;
				else
					pin_next = cur;
			end else begin
				pin_next = 1'b0;
			end
		end
	endfunction

	// register select: index against printed offset less the block base
	function reg_sel;
		input [15:0] idx;
		input [15:0] ofs;
		begin
			reg_sel = (idx == (ofs - `IDX_BASE));
		end
	endfunction

	wire div4_edge = (prescale_cnt == `DIV4_LAST);
	wire ch1_tick = tick_sel(ch1_counter_control, div4_edge) && ch1_run_bit;
	wire ch2_tick = tick_sel(ch2_counter_control, div4_edge) && ch2_run_bit;
	wire [1:0] ch1_clr = ch1_counter_control[`CLR_SRC_HI:`CLR_SRC_LO];
	wire [1:0] ch2_clr = ch2_counter_control[`CLR_SRC_HI:`CLR_SRC_LO];
	wire ch1_pwm2 = (ch1_operating_mode[1:0] == `MODE_PWM2);
	wire ch2_pwm2 = (ch2_operating_mode[1:0] == `MODE_PWM2);

	// compare matches counted on a tick while the counter holds the value
	wire ch1_match_a = ch1_tick && (ch1_up_counter == ch1_compare_a_duty);
	wire ch1_match_b = ch1_tick && (ch1_up_counter == ch1_compare_b_duty);
	wire ch2_match_a = ch2_tick && (ch2_up_counter == ch2_compare_a_duty);
	wire ch2_match_b = ch2_tick && (ch2_up_counter == ch2_compare_b_period);

	// own clear sources
	wire ch1_own_clr = (ch1_clr == `CLR_BY_GRB) && ch1_match_b;
	wire ch2_own_clr = (ch2_clr == `CLR_BY_GRB) && ch2_match_b;
	// synchronous clears across joined channels
	wire both_sync = ch1_sync_join && ch2_sync_join;
	wire ch1_clear = ch1_own_clr ||
		(both_sync && (ch1_clr == `CLR_BY_SYNC) && ch2_own_clr);
	wire ch2_clear = ch2_own_clr ||
		(both_sync && (ch2_clr == `CLR_BY_SYNC) && ch1_own_clr);

	// bus decode: byte address is four times the register index
	wire [15:0] reg_idx = {2'h0, address[15:2]};
	wire bus_req = (read || write) && !answered;
	wire full16 = (byteenable[1:0] == 2'h3);
	// writes land at the answer edge, when waitrequest is seen low
	wire wr = write && !waitrequest;
	wire wr8 = wr && byteenable[0];
	wire wr16 = wr && full16;
	wire [15:0] wdata16 = writedata[15:0];
	wire [15:0] base_idx = `IDX_BASE;
	wire hit_st = reg_sel(reg_idx, `OFS_START) && wr8;
	wire hit_sy = reg_sel(reg_idx, `OFS_SYNC) && wr8;
	wire hit_c1c = reg_sel(reg_idx, `OFS_CH1_CTRL) && wr8;
	wire hit_c1m = reg_sel(reg_idx, `OFS_CH1_MODE) && wr8;
	wire hit_c1p = reg_sel(reg_idx, `OFS_CH1_PIN) && wr8;
	wire hit_c1n = reg_sel(reg_idx, `OFS_CH1_CNT) && wr16;
	wire hit_c1a = reg_sel(reg_idx, `OFS_CH1_GRA) && wr16;
	wire hit_c1b = reg_sel(reg_idx, `OFS_CH1_GRB) && wr16;
	wire hit_c2c = reg_sel(reg_idx, `OFS_CH2_CTRL) && wr8;
	wire hit_c2m = reg_sel(reg_idx, `OFS_CH2_MODE) && wr8;
	wire hit_c2p = reg_sel(reg_idx, `OFS_CH2_PIN) && wr8;
	wire hit_c2n = reg_sel(reg_idx, `OFS_CH2_CNT) && wr16;
	wire hit_c2a = reg_sel(reg_idx, `OFS_CH2_GRA) && wr16;
	wire hit_c2b = reg_sel(reg_idx, `OFS_CH2_GRB) && wr16;
	// a counter write presets the joined partner too
	wire preset1 = hit_c1n || (both_sync && hit_c2n);
	wire preset2 = hit_c2n || (both_sync && hit_c1n);
	wire [15:0] preset_val = wdata16;

	// read mux; unmapped indexes read as zero
	always @* begin
		next_readdata = 32'h00000000;
		case (reg_idx)
		`OFS_START - base_idx: next_readdata[7:0] = start_reg;
		`OFS_SYNC - base_idx: next_readdata[7:0] = sync_reg;
		`OFS_CH1_CTRL - base_idx: next_readdata[7:0] = ch1_counter_control;
		`OFS_CH1_MODE - base_idx: next_readdata[7:0] = ch1_operating_mode;
		`OFS_CH1_PIN - base_idx: next_readdata[7:0] = ch1_pin_compare_setup;
		`OFS_CH1_CNT - base_idx: next_readdata[15:0] = ch1_up_counter;
		`OFS_CH1_GRA - base_idx: next_readdata[15:0] = ch1_compare_a_duty;
		`OFS_CH1_GRB - base_idx: next_readdata[15:0] = ch1_compare_b_duty;
		`OFS_CH2_CTRL - base_idx: next_readdata[7:0] = ch2_counter_control;
		`OFS_CH2_MODE - base_idx: next_readdata[7:0] = ch2_operating_mode;
		`OFS_CH2_PIN - base_idx: next_readdata[7:0] = ch2_pin_compare_setup;
		`OFS_CH2_CNT - base_idx: next_readdata[15:0] = ch2_up_counter;
		`OFS_CH2_GRA - base_idx: next_readdata[15:0] = ch2_compare_a_duty;
		`OFS_CH2_GRB - base_idx: next_readdata[15:0] = ch2_compare_b_period;
		default: next_readdata = 32'h00000000;
		endcase
	end

	// one wait cycle, then the answer edge; answered blocks a second take
	always @(posedge clk) begin
		if (sys_rst) begin
			waitrequest <= 1'b1;
			answered <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			waitrequest <= !bus_req;
			answered <= bus_req;
			if (bus_req && read)
				readdata <= next_readdata;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			prescale_cnt <= 2'h0;
			start_reg <= 8'h00;
			sync_reg <= 8'h00;
			ch1_counter_control <= `CTRL_RESET;
			ch1_operating_mode <= `MODE_RESET;
			ch1_pin_compare_setup <= `PIN_RESET;
			ch2_counter_control <= `CTRL_RESET;
			ch2_operating_mode <= `MODE_RESET;
			ch2_pin_compare_setup <= `PIN_RESET;
		end else begin
			prescale_cnt <= prescale_cnt + 2'h1;
			if (hit_st)
				start_reg <= writedata[7:0] & 8'h06;
			if (hit_sy)
				sync_reg <= writedata[7:0] & 8'h06;
			if (hit_c1c)
				ch1_counter_control <= writedata[7:0] & 8'h7f;
			if (hit_c1m)
				ch1_operating_mode <= writedata[7:0];
			if (hit_c1p)
				ch1_pin_compare_setup <= writedata[7:0];
			if (hit_c2c)
				ch2_counter_control <= writedata[7:0] & 8'h7f;
			if (hit_c2m)
				ch2_operating_mode <= writedata[7:0];
			if (hit_c2p)
				ch2_pin_compare_setup <= writedata[7:0];
		end
	end

	// 16-bit compare registers, whole-word writes only
	always @(posedge clk) begin
		if (sys_rst) begin
			ch1_compare_a_duty <= `GR_RESET;
			ch1_compare_b_duty <= `GR_RESET;
			ch2_compare_a_duty <= `GR_RESET;
			ch2_compare_b_period <= `GR_RESET;
		end else begin
			if (hit_c1a)
				ch1_compare_a_duty <= wdata16;
			if (hit_c1b)
				ch1_compare_b_duty <= wdata16;
			if (hit_c2a)
				ch2_compare_a_duty <= wdata16;
			if (hit_c2b)
				ch2_compare_b_period <= wdata16;
		end
	end

	// counters: preset beats clear beats count
	always @* begin
		next_ch1_up_counter = ch1_up_counter;
		if (preset1)
			next_ch1_up_counter = preset_val;
		else if (ch1_clear)
			next_ch1_up_counter = `CNT_RESET;
		else if (ch1_tick)
			next_ch1_up_counter = ch1_up_counter + 16'h0001;
	end

	always @* begin
		next_ch2_up_counter = ch2_up_counter;
		if (preset2)
			next_ch2_up_counter = preset_val;
		else if (ch2_clear)
			next_ch2_up_counter = `CNT_RESET;
		else if (ch2_tick)
			next_ch2_up_counter = ch2_up_counter + 16'h0001;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			ch1_up_counter <= `CNT_RESET;
			ch2_up_counter <= `CNT_RESET;
		end else begin
			ch1_up_counter <= next_ch1_up_counter;
			ch2_up_counter <= next_ch2_up_counter;
		end
	end

	// pwm mode 2 pins; other modes hold pins low
	wire next_pwm_out_phase1 = ch1_pwm2 && pin_next(ch1_pin_compare_setup[3:0],
		pwm_out_phase1, ch1_match_a, ch1_clear);
	wire next_pwm_out_phase2 = ch1_pwm2 && pin_next(ch1_pin_compare_setup[7:4],
		pwm_out_phase2, ch1_match_b, ch1_clear);
	wire next_pwm_out_phase3 = ch2_pwm2 && pin_next(ch2_pin_compare_setup[3:0],
		pwm_out_phase3, ch2_match_a, ch2_clear);
	wire next_ch2_pin_b_unused = ch2_pwm2 && pin_next(ch2_pin_compare_setup[7:4],
		ch2_pin_b_unused, ch2_match_b, ch2_clear);

	always @(posedge clk) begin
		if (sys_rst) begin
			pwm_out_phase1 <= 1'b0;
			pwm_out_phase2 <= 1'b0;
			pwm_out_phase3 <= 1'b0;
			ch2_pin_b_unused <= 1'b0;
		end else begin
			pwm_out_phase1 <= next_pwm_out_phase1;
			pwm_out_phase2 <= next_pwm_out_phase2;
			pwm_out_phase3 <= next_pwm_out_phase3;
			ch2_pin_b_unused <= next_ch2_pin_b_unused;
		end
	end

endmodule // three_phase_pwm_timer_pair

/* bench/pwm_timer_monitor.sv */
/* checker for the pwm timer pair: bus answer timing and pin relations.
 assumes one clk and a synchronous active-high sys_rst. */
`timescale 1ns/10ps
module pwm_timer_monitor (
	input wire clk,
	input wire sys_rst,
	input wire [15:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire pwm_out_phase1,
	input wire pwm_out_phase2,
	input wire pwm_out_phase3,
	input wire ch2_pin_b_unused
);
	reg [3:0] pinb_cfg;
	// shadow of the ch2 compare b pin field
	always @(posedge clk) begin
		if (sys_rst)
			pinb_cfg <= 4'h0;
		else if (write && !waitrequest && address == 16'hc148 && byteenable[0])
			pinb_cfg <= writedata[7:4];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ack_latency: assert property ((read || write) && waitrequest && $past(waitrequest)
		|=> !waitrequest) else $error("answer not one cycle after request");
	a_ack_single: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	a_idle_quiet: assert property (!read && !write |=> waitrequest)
		else $error("answer without request");
	a_upper_zero: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_reset_pins: assert property (disable iff (1'b0) sys_rst
		|=> !pwm_out_phase1 && !pwm_out_phase2 && !pwm_out_phase3) else $error("pin high in reset");
	a_pinb_off: assert property (pinb_cfg == 4'h0 |=> !ch2_pin_b_unused)
		else $error("disabled pin driven high");
	a_fall_together: assert property ($fell(pwm_out_phase1)
		|-> !pwm_out_phase2 && !pwm_out_phase3) else $error("phases not cleared together");
	a_high_tick: assert property ($rose(pwm_out_phase1) |=> pwm_out_phase1 [*3])
		else $error("phase one high less than one tick");
endmodule // pwm_timer_monitor

bind three_phase_pwm_timer_pair pwm_timer_monitor mon_u (.clk(clk), .sys_rst(sys_rst),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.pwm_out_phase1(pwm_out_phase1), .pwm_out_phase2(pwm_out_phase2),
	.pwm_out_phase3(pwm_out_phase3), .ch2_pin_b_unused(ch2_pin_b_unused));

/* bench/pwm_power_stage.sv */
/* stand-in for the three-phase power stage: low width of each phase before
 its last rise, and rise-to-rise period of phase one, in clocks. */
`timescale 1ns/10ps
module pwm_power_stage (
	input wire clk,
	input wire [2:0] phase,
	output reg [15:0] low1,
	output reg [15:0] low2,
	output reg [15:0] low3,
	output reg [15:0] period1
);
	reg [15:0] run [0:2];
	reg [15:0] per_run = 16'h0;
	reg [2:0] last = 3'h0;
	wire [2:0] rise = phase & ~last;
	initial {low1, low2, low3, period1, run[0], run[1], run[2]} = 0;
	always @(posedge clk) begin
		last <= phase;
		per_run <= rise[0] ? 16'h1 : per_run + 16'h1;
		for (int k = 0; k < 3; k++)
			run[k] <= phase[k] ? 16'h0 : run[k] + 16'h1;
		if (rise[0]) begin
			period1 <= per_run;
			low1 <= run[0];
		end
		if (rise[1])
			low2 <= run[1];
		if (rise[2])
			low3 <= run[2];
	end
endmodule // pwm_power_stage

/* bench/three_phase_pwm_timer_pair_bench.sv */
/* bench for the pwm timer pair: register checks over avalon-mm, then a short
 synchronised pwm run measured by the power stage model, then a stop, a reset
 and two count codes that must leave the counter still. */
`timescale 1ns/10ps
`include "pwm_timer_defs.vh"
module three_phase_pwm_timer_pair_bench;
	reg clk, sys_rst, read, write;
	reg [15:0] address;
	reg [31:0] writedata, rd;
	reg [3:0] byteenable;
	wire [31:0] readdata;
	wire waitrequest, p1, p2, p3, pb;
	wire [15:0] w1, w2, w3, per;
	int miscompares = 0;
	int n_tests = 0;
	three_phase_pwm_timer_pair dut_u (.clk(clk), .sys_rst(sys_rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .pwm_out_phase1(p1),
		.pwm_out_phase2(p2), .pwm_out_phase3(p3), .ch2_pin_b_unused(pb));
	pwm_power_stage stage_u (.clk(clk), .phase({p3, p2, p1}), .low1(w1), .low2(w2),
		.low3(w3), .period1(per));
	task end_of_test;
		begin
			$display("comparisons %0d miscompares %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] got, input [31:0] exp);
		begin
			n_tests++;
			if (got !== exp) begin
				miscompares++;
				$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// register index sits at the printed offset minus 0xc000
	task bus(input bit w, input [15:0] o, input [31:0] d, input [3:0] be);
		int i;
		begin
			@(posedge clk);
			address <= {o[13:0], 2'h0};
			read <= !w;
			write <= w;
			writedata <= d;
			byteenable <= be;
			i = 0;
			@(posedge clk);
			while (waitrequest !== 1'b0 && i < 50) begin
				@(posedge clk);
				i++;
			end
			if (i == 50) begin
				miscompares++;
				end_of_test;
			end
			rd = readdata;
			read <= 1'b0;
			write <= 1'b0;
		end
	endtask
	task wr(input [15:0] o, input [31:0] d);
		bus(1'b1, o, d, 4'hf);
	endtask
	task rdc(input string nm, input [15:0] o, input [31:0] exp);
		begin
			bus(1'b0, o, 32'h0, 4'hf);
			chk(nm, rd, exp);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		{read, write, address, writedata, byteenable} = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rdc("cnt1", `OFS_CH1_CNT, 32'h0);
		rdc("cnt2", `OFS_CH2_CNT, 32'h0);
		rdc("gra1", `OFS_CH1_GRA, 32'hffff);
		rdc("grb1", `OFS_CH1_GRB, 32'hffff);
		rdc("gra2", `OFS_CH2_GRA, 32'hffff);
		rdc("grb2", `OFS_CH2_GRB, 32'hffff);
		wr(`OFS_CH1_GRA, 32'h1234);
		rdc("gra1 rw", `OFS_CH1_GRA, 32'h1234);
		bus(1'b1, `OFS_CH1_GRA, 32'h5678, 4'h1);
		rdc("gra1 byte", `OFS_CH1_GRA, 32'h1234);
		rdc("unmapped", 16'hf070, 32'h0);
		wr(`OFS_CH1_CTRL, 32'h61);
		wr(`OFS_CH2_CTRL, 32'h41);
		wr(`OFS_CH1_MODE, 32'h3);
		wr(`OFS_CH2_MODE, 32'h3);
		wr(`OFS_CH1_PIN, 32'h22);
		wr(`OFS_CH2_PIN, 32'h02);
		rdc("pin1 setup", `OFS_CH1_PIN, 32'h22);
		wr(`OFS_CH1_GRA, 32'h2);
		wr(`OFS_CH1_GRB, 32'h4);
		wr(`OFS_CH2_GRA, 32'h6);
		wr(`OFS_CH2_GRB, 32'h9);
		wr(`OFS_SYNC, 32'h6);
		wr(`OFS_CH2_CNT, 32'h3);
		rdc("preset", `OFS_CH1_CNT, 32'h3);
		wr(`OFS_START, 32'h6);
		repeat (200) @(posedge clk);
		chk("low1", w1, 32'hc);
		chk("low2", w2, 32'h14);
		chk("low3", w3, 32'h1c);
		chk("period", per, 32'h28);
		chk("pin b", pb, 32'h0);
		wr(`OFS_START, 32'h0);
		wr(`OFS_CH2_CNT, 32'h7);
		repeat (40) @(posedge clk);
		rdc("stopped", `OFS_CH2_CNT, 32'h7);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		chk("pins rst", {p3, p2, p1, pb}, 32'h0);
		rdc("mode1 rst", `OFS_CH1_MODE, {24'h0, `MODE_RESET});
		rdc("cnt2 rst", `OFS_CH2_CNT, 32'h0);
		rdc("grb2 rst", `OFS_CH2_GRB, 32'hffff);
		wr(`OFS_START, 32'h6);
		repeat (20) @(posedge clk);
		rdc("no prescale", `OFS_CH1_CNT, 32'h0);
		wr(`OFS_CH1_CTRL, 32'h09);
		repeat (20) @(posedge clk);
		rdc("edge code", `OFS_CH1_CNT, 32'h0);
		end_of_test;
	end
endmodule // three_phase_pwm_timer_pair_bench
